// ---- hw/gtssc_pkg.sv ----
// Shared constants and types for the transmit shaping and synthesizer control block
package gtssc_pkg;
  // Clock and timing
  localparam int CLK_NS = 40;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_NS;
  localparam int LAUNCH_NS = 2500;
  localparam int LAUNCH_CYC = (LAUNCH_NS + CLK_NS - 1) / CLK_NS;
  // Sample points inside one bit period (four samples per bit)
  localparam int SAMP_STEP = 6;
  // Deviation used by the computed table entry figure in the bench, in hertz
  localparam int DEV_HZ = 157500;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DELAY = 8'h04;
  localparam logic [7:0] ADDR_SLOPE = 8'h08;
  localparam logic [7:0] ADDR_INTV = 8'h0C;
  localparam logic [7:0] ADDR_NUM = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_TBL = 8'h20;
  // Control field positions
  localparam int CTRL_TX = 0;
  localparam int CTRL_RX = 1;
  localparam int CTRL_NB = 2;
  // Delay register fields: start delay in [15:8], intercept in [7:0]
  localparam int DLY_LSB = 8;
  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // Widths and table layout
  localparam int FRAC_W = 16;
  localparam int TBL_N = 11;
  localparam int TBL_W = 8;
  localparam logic [16:0] INT_BIAS = 17'h00003;
  localparam logic [3:0] RAMP_MAX = 4'hF;
  localparam logic [3:0] TI_HOLD = 4'h0;
  localparam logic [3:0] TI_ROW2 = 4'h1;
  localparam logic [3:0] TI_ROW3 = 4'h4;
  localparam logic [3:0] TI_ROW4 = 4'h8;
  // Cycle states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_TX = 5'b00100,
    ST_RX = 5'b01000,
    ST_RAMPDN = 5'b10000
  } gtssc_state_t;
endpackage : gtssc_pkg

// ---- hw/gtssc_accum.sv ----
// One first-order accumulator stage of the fractional-N modulator
`timescale 1ns/1ps
module gtssc_accum #(
  parameter int W = gtssc_pkg::FRAC_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] addend,
  output logic [W-1:0] acc,
  output logic carry
);
  logic [W-1:0] acc_r;
  logic carry_r;
  logic [W:0] sum;

  // Wide sum keeps the overflow bit as the carry
  assign sum = {1'b0, acc_r} + {1'b0, addend};
  assign acc = acc_r;
  assign carry = carry_r;

  // Accumulate every clock, carry out registered
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_r <= '0;
      carry_r <= 1'b0;
    end else begin
      acc_r <= sum[W-1:0];
      carry_r <= sum[W];
    end
  end
endmodule : gtssc_accum

// ---- hw/gtssc_traj.sv ----
// Trajectory selector: bit history and sample point to table entry and sign
`timescale 1ns/1ps
module gtssc_traj (
  input wire logic [2:0] hist,
  input wire logic [1:0] sampIdx,
  output logic [3:0] entryIdx,
  output logic negative
);
  logic runOld;
  logic runNew;
  logic [3:0] colNoC1;

  // hist[0] is the current bit, hist[2] the oldest
  assign runOld = hist[2] == hist[1];
  assign runNew = hist[1] == hist[0];
  // Rows two and four have no first column, so sample 0 reuses column two
  assign colNoC1 = (sampIdx == 2'h0) ? 4'h0 : {2'h0, sampIdx} - 4'h1;
  assign negative = !hist[0]; // Mirror the single quadrant for a zero bit

  // Pick one of four trajectories from three bits
  always_comb begin
    if (runOld && runNew) begin
      entryIdx = gtssc_pkg::TI_HOLD;
    end else if (runNew) begin
      entryIdx = gtssc_pkg::TI_ROW2 + colNoC1;
    end else if (runOld) begin
      entryIdx = gtssc_pkg::TI_ROW3 + {2'h0, sampIdx};
    end else begin
      entryIdx = gtssc_pkg::TI_ROW4 + colNoC1;
    end
  end
endmodule : gtssc_traj

// ---- hw/gtssc_core.sv ----
// Transmit shaping, start delay, power sequencing and fractional-N control
`timescale 1ns/1ps
module gtssc_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic cycleEnable,
  input wire logic txBit,
  output logic bitReq,
  output logic airData,
  output logic trimActive,
  output logic [2:0] stageEn,
  output logic [3:0] rampLevel,
  output logic [7:0] modDac,
  output logic [16:0] divRatio
);
  // Register file
  logic [2:0] ctrl_r;
  logic [7:0] delay_r;
  logic [7:0] icpt_r;
  logic [7:0] slope_r;
  logic [15:0] intVal_r;
  logic [15:0] num_r;
  logic [gtssc_pkg::TBL_W-1:0] table_r [gtssc_pkg::TBL_N];

  // Bus signals
  logic wbAck_r;
  logic [31:0] wbDatR_r;
  logic busHit;
  logic wrHit;
  logic [7:0] wordAdr;
  logic tblHit;
  logic [3:0] tblIdx;
  logic [7:0] tblOff;

  // Sequencing state
  gtssc_pkg::gtssc_state_t state_r;
  gtssc_pkg::gtssc_state_t state_nxt;
  logic cycPrev_r;
  logic cycRise;
  logic txMode;
  logic rxMode;
  logic [4:0] phase_r;
  logic usTick;
  logic [7:0] dlyCnt_r;
  logic [6:0] lnchCnt_r;
  logic [2:0] hist_r;
  logic [1:0] sampIdx;
  logic bitStart;

  // Output registers
  logic bitReq_r;
  logic airData_r;
  logic trimActive_r;
  logic [2:0] stageEn_r;
  logic [3:0] rampLevel_r;
  logic [7:0] modDac_r;
  logic [16:0] divRatio_r;

  // Shaping and synthesizer path
  logic [3:0] entryIdx;
  logic negative;
  logic [8:0] shaped_r;
  logic [8:0] shaped_nxt;
  logic [8:0] mag;
  logic [15:0] fracIn;
  logic [15:0] acc1;
  logic [15:0] acc2;
  logic [15:0] acc3Unused;
  logic c1;
  logic c2;
  logic c3;
  logic c2d_r;
  logic c3d_r;
  logic c3dd_r;
  logic [4:0] mashOut;
  logic signed [15:0] prod;

  assign wbAck = wbAck_r;
  assign wbDatR = wbDatR_r;
  assign bitReq = bitReq_r;
  assign airData = airData_r;
  assign trimActive = trimActive_r;
  assign stageEn = stageEn_r;
  assign rampLevel = rampLevel_r;
  assign modDac = modDac_r;
  assign divRatio = divRatio_r;

  // Bus decode: one new request per cycle while ack is low
  assign busHit = wbCyc && wbStb && !wbAck_r;
  assign wrHit = busHit && wbWe;
  assign wordAdr = {wbAdr[7:2], 2'h0};
  assign tblOff = wordAdr - gtssc_pkg::ADDR_TBL;
  assign tblIdx = tblOff[5:2];
  assign tblHit = (wordAdr >= gtssc_pkg::ADDR_TBL) && (tblOff[7:2] < 6'(gtssc_pkg::TBL_N));

  // Acknowledge one cycle after the request, then drop
  always_ff @(posedge clock) begin
    if (rst) begin
      wbAck_r <= 1'b0;
    end else begin
      wbAck_r <= busHit;
    end
  end

  // Control and synthesizer word writes, byte lanes honoured
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= gtssc_pkg::CTRL_RST;
      delay_r <= gtssc_pkg::DELAY_RST;
      icpt_r <= gtssc_pkg::BYTE_RST;
      slope_r <= gtssc_pkg::BYTE_RST;
      intVal_r <= gtssc_pkg::WORD_RST;
      num_r <= gtssc_pkg::WORD_RST;
    end else if (wrHit) begin
      unique case (wordAdr)
        gtssc_pkg::ADDR_CTRL: begin
          if (wbSel[0]) ctrl_r <= wbDatW[2:0];
        end
        gtssc_pkg::ADDR_DELAY: begin
          if (wbSel[0]) icpt_r <= wbDatW[7:0];
          if (wbSel[1]) delay_r <= wbDatW[15:8];
        end
        gtssc_pkg::ADDR_SLOPE: begin
          if (wbSel[1]) slope_r <= wbDatW[15:8];
        end
        gtssc_pkg::ADDR_INTV: begin
          if (wbSel[0]) intVal_r[7:0] <= wbDatW[7:0];
          if (wbSel[1]) intVal_r[15:8] <= wbDatW[15:8];
        end
        gtssc_pkg::ADDR_NUM: begin
          if (wbSel[0]) num_r[7:0] <= wbDatW[7:0];
          if (wbSel[1]) num_r[15:8] <= wbDatW[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // Trajectory table writes, eleven byte entries
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < gtssc_pkg::TBL_N; i++) begin
        table_r[i] <= gtssc_pkg::BYTE_RST;
      end
    end else if (wrHit && tblHit && wbSel[0]) begin
      table_r[tblIdx] <= wbDatW[7:0];
    end
  end

  // Read data, unmapped words read as zero
  always_ff @(posedge clock) begin
    if (rst) begin
      wbDatR_r <= '0;
    end else if (busHit && !wbWe) begin
      if (tblHit) begin
        wbDatR_r <= {24'h000000, table_r[tblIdx]};
      end else begin
        unique case (wordAdr)
          gtssc_pkg::ADDR_CTRL: wbDatR_r <= {29'h00000000, ctrl_r};
          gtssc_pkg::ADDR_DELAY: wbDatR_r <= {16'h0000, delay_r, icpt_r};
          gtssc_pkg::ADDR_SLOPE: wbDatR_r <= {16'h0000, slope_r, 8'h00};
          gtssc_pkg::ADDR_INTV: wbDatR_r <= {16'h0000, intVal_r};
          gtssc_pkg::ADDR_NUM: wbDatR_r <= {16'h0000, num_r};
          gtssc_pkg::ADDR_STATUS: begin
            wbDatR_r <= {12'h000, hist_r, stageEn_r, rampLevel_r, airData_r, trimActive_r, 3'h0, state_r};
          end
          default: wbDatR_r <= '0;
        endcase
      end
    end
  end

  // Cycle enable edge and mode decode
  assign cycRise = cycleEnable && !cycPrev_r;
  assign txMode = ctrl_r[gtssc_pkg::CTRL_TX] && ctrl_r[gtssc_pkg::CTRL_NB] && !ctrl_r[gtssc_pkg::CTRL_RX];
  assign rxMode = ctrl_r[gtssc_pkg::CTRL_RX] && !ctrl_r[gtssc_pkg::CTRL_TX];

  always_ff @(posedge clock) begin
    if (rst) begin
      cycPrev_r <= 1'b0;
    end else begin
      cycPrev_r <= cycleEnable;
    end
  end

  // Microsecond and bit-period divider, restarted at cycle start and at delay end
  assign usTick = phase_r == 5'(gtssc_pkg::US_CYC - 1);
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_r <= '0;
    end else if (cycRise || usTick || (state_r == gtssc_pkg::ST_DELAY && state_nxt == gtssc_pkg::ST_TX)) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 5'h01;
    end
  end

  // Next state of the cycle sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      gtssc_pkg::ST_IDLE: begin
        if (cycRise && txMode) state_nxt = gtssc_pkg::ST_DELAY;
        else if (cycRise && rxMode) state_nxt = gtssc_pkg::ST_RX;
      end
      gtssc_pkg::ST_DELAY: begin
        if (!cycleEnable) state_nxt = gtssc_pkg::ST_RAMPDN;
        else if (dlyCnt_r == 8'h00) state_nxt = gtssc_pkg::ST_TX;
      end
      gtssc_pkg::ST_TX: begin
        if (!cycleEnable) state_nxt = gtssc_pkg::ST_RAMPDN;
      end
      gtssc_pkg::ST_RX: begin
        if (!cycleEnable) state_nxt = gtssc_pkg::ST_IDLE;
      end
      gtssc_pkg::ST_RAMPDN: begin
        if (rampLevel_r == 4'h0) state_nxt = gtssc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= gtssc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Start delay in whole microseconds from the programmed byte
  always_ff @(posedge clock) begin
    if (rst) begin
      dlyCnt_r <= 8'h00;
    end else if (cycRise) begin
      dlyCnt_r <= delay_r;
    end else if (state_r == gtssc_pkg::ST_DELAY && usTick && dlyCnt_r != 8'h00) begin
      dlyCnt_r <= dlyCnt_r - 8'h01;
    end
  end

  // Oscillator trim runs through the start delay with no software action
  always_ff @(posedge clock) begin
    if (rst) begin
      trimActive_r <= 1'b0;
    end else begin
      trimActive_r <= state_nxt == gtssc_pkg::ST_DELAY;
    end
  end

  // Power stages switch on one per clock after trim, off after ramp-down
  always_ff @(posedge clock) begin
    if (rst) begin
      stageEn_r <= 3'h0;
    end else if (state_r == gtssc_pkg::ST_TX) begin
      stageEn_r <= {stageEn_r[1:0], 1'b1};
    end else if (state_r != gtssc_pkg::ST_RAMPDN || rampLevel_r == 4'h0) begin
      stageEn_r <= 3'h0;
    end
  end

  // Output ramp up once all stages are on, ramp down when the cycle ends
  always_ff @(posedge clock) begin
    if (rst) begin
      rampLevel_r <= 4'h0;
    end else if (state_r == gtssc_pkg::ST_TX && stageEn_r[2] && rampLevel_r != gtssc_pkg::RAMP_MAX) begin
      rampLevel_r <= rampLevel_r + 4'h1;
    end else if (state_r == gtssc_pkg::ST_RAMPDN && rampLevel_r != 4'h0) begin
      rampLevel_r <= rampLevel_r - 4'h1;
    end
  end

  // Data reaches the antenna a fixed launch time after the delay
  always_ff @(posedge clock) begin
    if (rst) begin
      lnchCnt_r <= 7'h00;
      airData_r <= 1'b0;
    end else if (state_r != gtssc_pkg::ST_TX) begin
      lnchCnt_r <= 7'h00;
      airData_r <= 1'b0;
    end else if (lnchCnt_r == 7'(gtssc_pkg::LAUNCH_CYC - 1)) begin
      airData_r <= 1'b1;
    end else begin
      lnchCnt_r <= lnchCnt_r + 7'h01;
    end
  end

  // Bit history: cleared at cycle start, new bit each bit period
  assign bitStart = state_r == gtssc_pkg::ST_TX && phase_r == 5'h00;
  always_ff @(posedge clock) begin
    if (rst) begin
      hist_r <= 3'h0;
      bitReq_r <= 1'b0;
    end else begin
      bitReq_r <= bitStart;
      if (cycRise) begin
        hist_r <= 3'h0;
      end else if (bitStart) begin
        hist_r <= {hist_r[1:0], txBit};
      end
    end
  end

  // Four sample points per bit period
  always_comb begin
    if (phase_r >= 5'(3 * gtssc_pkg::SAMP_STEP)) sampIdx = 2'h3;
    else if (phase_r >= 5'(2 * gtssc_pkg::SAMP_STEP)) sampIdx = 2'h2;
    else if (phase_r >= 5'(gtssc_pkg::SAMP_STEP)) sampIdx = 2'h1;
    else sampIdx = 2'h0;
  end

  gtssc_traj uTraj (
    .hist(hist_r),
    .sampIdx(sampIdx),
    .entryIdx(entryIdx),
    .negative(negative)
  );

  // Shaped value: signed trajectory in transmit, hold entry otherwise
  assign mag = {1'b0, table_r[entryIdx]};
  always_comb begin
    if (state_r == gtssc_pkg::ST_TX) begin
      shaped_nxt = negative ? (9'h000 - mag) : mag;
    end else begin
      shaped_nxt = {1'b0, table_r[gtssc_pkg::TI_HOLD]};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      shaped_r <= 9'h000;
    end else begin
      shaped_r <= shaped_nxt;
    end
  end

  // Table output times four added to the numerator feeds the accumulators
  assign fracIn = num_r + {{5{shaped_r[8]}}, shaped_r, 2'h0};

  // Three cascaded accumulators
  gtssc_accum uAcc1 (
    .clock(clock),
    .rst(rst),
    .addend(fracIn),
    .acc(acc1),
    .carry(c1)
  );
  gtssc_accum uAcc2 (
    .clock(clock),
    .rst(rst),
    .addend(acc1),
    .acc(acc2),
    .carry(c2)
  );
  gtssc_accum uAcc3 (
    .clock(clock),
    .rst(rst),
    .addend(acc2),
    .acc(acc3Unused),
    .carry(c3)
  );

  // Carry delays for the noise-shaping differences
  always_ff @(posedge clock) begin
    if (rst) begin
      c2d_r <= 1'b0;
      c3d_r <= 1'b0;
      c3dd_r <= 1'b0;
    end else begin
      c2d_r <= c2;
      c3d_r <= c3;
      c3dd_r <= c3d_r;
    end
  end

  // Combined offset, range -3 to +4, plus integer and bias gives the divide ratio
  assign mashOut = {4'h0, c1} + {4'h0, c2} - {4'h0, c2d_r} + {4'h0, c3} - {3'h0, c3d_r, 1'b0} + {4'h0, c3dd_r};
  always_ff @(posedge clock) begin
    if (rst) begin
      divRatio_r <= 17'h00000;
    end else begin
      divRatio_r <= {1'b0, intVal_r} + gtssc_pkg::INT_BIAS + {{12{mashOut[4]}}, mashOut};
    end
  end

  // Seven MSBs scaled by slope plus intercept drive the modulation port
  assign prod = $signed(shaped_r[8:2]) * $signed({1'b0, slope_r});
  always_ff @(posedge clock) begin
    if (rst) begin
      modDac_r <= 8'h00;
    end else begin
      modDac_r <= prod[14:7] + icpt_r;
    end
  end
endmodule : gtssc_core

// ---- sim/gtssc_chk.sv ----
// Port-level checker for the transmit shaping and synthesizer control block
`timescale 1ns/1ps
module gtssc_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  input wire logic cycleEnable,
  input wire logic txBit,
  input wire logic bitReq,
  input wire logic airData,
  input wire logic trimActive,
  input wire logic [2:0] stageEn,
  input wire logic [3:0] rampLevel,
  input wire logic [7:0] modDac,
  input wire logic [16:0] divRatio
);
  logic [7:0] dly_r;
  logic [15:0] intv_r;
  logic [12:0] trimCnt_r;
  logic wrAck;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // A write lands at the edge where ack is sampled
  assign wrAck = wbCyc && wbStb && wbWe && wbAck;
  // Shadow copies of the start delay and the integer value
  always_ff @(posedge clock) begin
    if (rst) begin
      dly_r <= 8'h00;
      intv_r <= 16'h0000;
    end else if (wrAck && wbAdr[7:2] == gtssc_pkg::ADDR_DELAY[7:2]) begin
      dly_r <= wbDatW[15:8];
    end else if (wrAck && wbAdr[7:2] == gtssc_pkg::ADDR_INTV[7:2]) begin
      intv_r <= wbDatW[15:0];
    end
  end
  // Length of the oscillator trim phase
  always_ff @(posedge clock) begin
    if (rst) trimCnt_r <= 13'h0000;
    else if (trimActive) trimCnt_r <= trimCnt_r + 13'h0001;
    else trimCnt_r <= 13'h0000;
  end
  sequence s_trimEnd;
    $fell(trimActive) && cycleEnable;
  endsequence
  sequence s_fill;
    ##1 stageEn == 3'h3 ##1 stageEn == 3'h7;
  endsequence
  ack_one_cycle_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  start_delay_a: assert property (s_trimEnd |-> trimCnt_r == 13'(int'(dly_r) * gtssc_pkg::US_CYC + 1))
    else $error("start delay length wrong");
  first_bit_a: assert property (s_trimEnd |-> ##[0:1] bitReq)
    else $error("first bit not taken after delay");
  air_launch_a: assert property ($rose(airData) |-> $past(bitReq, 62))
    else $error("air data launch time wrong");
  air_stage_a: assert property (airData |-> !trimActive && stageEn == 3'h7)
    else $error("air data without full stages");
  stage_order_a: assert property (stageEn inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("stage enables out of order");
  stage_fill_a: assert property ($rose(stageEn[0]) |-> s_fill)
    else $error("stages not filled one per clock");
  ramp_step_a: assert property (4'(rampLevel - $past(rampLevel)) inside {4'h0, 4'h1, 4'hF})
    else $error("ramp jumped by more than one");
  ramp_gate_a: assert property (rampLevel != 4'h0 |-> stageEn == 3'h7)
    else $error("ramp active before last stage");
  div_range_a: assert property (intv_r == $past(intv_r, 8) |->
    divRatio >= 17'(intv_r) && divRatio <= 17'(intv_r) + 17'h00007)
    else $error("divider ratio outside modulator range");
endmodule : gtssc_chk

bind gtssc_core gtssc_chk gtssc_chk_inst (.clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
  .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
  .cycleEnable(cycleEnable), .txBit(txBit), .bitReq(bitReq), .airData(airData), .trimActive(trimActive),
  .stageEn(stageEn), .rampLevel(rampLevel), .modDac(modDac), .divRatio(divRatio));

// ---- sim/gtssc_bb_model.sv ----
// Baseband model: cycle enable and serial transmit bits with preamble
`timescale 1ns/1ps
module gtssc_bb_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic bitReq,
  output logic cycleEnable,
  output logic txBit
);
  logic [7:0] bitIdx_r;
  logic idle_r;
  // Cycle enable follows the run command, high for a cycle, low for idle
  always_ff @(posedge clock) begin
    if (rst) cycleEnable <= 1'b0;
    else cycleEnable <= run;
  end
  // Count bits taken by the device, restarting every cycle
  always_ff @(posedge clock) begin
    if (rst || !cycleEnable) bitIdx_r <= 8'h00;
    else if (bitReq) bitIdx_r <= bitIdx_r + 8'h01;
  end
  // Toggling level outside cycles so no stale bit is left on the line
  always_ff @(posedge clock) begin
    if (rst) idle_r <= 1'b0;
    else idle_r <= ~idle_r;
  end
  // Four alternating preamble bits, then ones
  assign txBit = cycleEnable ? (bitIdx_r < 8'h04 ? bitIdx_r[0] : 1'b1) : idle_r;
endmodule : gtssc_bb_model

// ---- sim/testbench.sv ----
// Self-checking bench for the transmit shaping and synthesizer control block
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] EXP_DAC = 8'(((32'h40 >> 2) * 32'h40 >> 7) + 32'h5);
  logic clock, rst, wbCyc, wbStb, wbWe, wbAck, run, cycleEnable, txBit, bitReq, airData, trimActive;
  logic [7:0] wbAdr, modDac;
  logic [3:0] wbSel, rampLevel;
  logic [31:0] wbDatW, wbDatR, rd;
  logic [2:0] stageEn;
  logic [16:0] divRatio;
  int err_count, total_checks;
  gtssc_core gtssc_core_inst (.clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .cycleEnable(cycleEnable),
    .txBit(txBit), .bitReq(bitReq), .airData(airData), .trimActive(trimActive), .stageEn(stageEn),
    .rampLevel(rampLevel), .modDac(modDac), .divRatio(divRatio));
  gtssc_bb_model gtssc_bb_model_inst (.clock(clock), .rst(rst), .run(run), .bitReq(bitReq),
    .cycleEnable(cycleEnable), .txBit(txBit));
  // Clock at 25 MHz
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Print the counts and the verdict, then stop
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // Compare one value
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // A wait that ran out of cycles ends the run
  task hang(input string nm);
    err_count++;
    $display("wrong value %s expected done seen timeout", nm);
    test_done();
  endtask : hang
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // One classic Wishbone cycle; read data is taken at the ack edge
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    wbSel <= 4'hF;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 16);
    if (wbAck !== 1'b1) hang("wishbone ack");
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb
  // Register reset values and an unmapped place
  task t_reset;
    wb(1'b0, gtssc_pkg::ADDR_STATUS, 32'h0);
    chk("status reset", 32'h0000_0001, rd);
    wb(1'b0, gtssc_pkg::ADDR_CTRL, 32'h0);
    chk("control reset", 32'h0000_0000, rd);
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    wb(1'b0, 8'hFC, 32'h0);
    chk("unmapped read", 32'h0000_0000, rd);
  endtask : t_reset
  // Integer and fractional divider values
  task t_synth;
    int sum;
    wb(1'b1, gtssc_pkg::ADDR_INTV, 32'h0000_00B8);
    wb(1'b1, gtssc_pkg::ADDR_NUM, 32'h0000_0000);
    cyc(16);
    chk("integer ratio", 32'h0000_00BB, 32'(divRatio));
    wb(1'b1, gtssc_pkg::ADDR_NUM, 32'h0000_8000);
    cyc(16);
    sum = 0;
    repeat (256) begin
      @(posedge clock);
      sum += int'(divRatio) - 187;
    end
    chk("half fraction", 32'h1, 32'(sum >= 125 && sum <= 131));
  endtask : t_synth
  // Table entries, then slope and intercept with the hold entry in idle
  task t_table;
    int tv;
    for (int k = 0; k < gtssc_pkg::TBL_N; k++) wb(1'b1, gtssc_pkg::ADDR_TBL + 8'(4 * k), 32'(8'h40 + k));
    for (int k = 0; k < gtssc_pkg::TBL_N; k++) begin
      wb(1'b0, gtssc_pkg::ADDR_TBL + 8'(4 * k), 32'h0);
      chk("table entry", 32'(8'h40 + k), rd);
    end
    // Row four, column two entry worked out as software would, from deviation and its constant
    tv = $rtoi((real'(gtssc_pkg::DEV_HZ) / 13.0e6 * 65536.0 * 0.5229292198 + 2.0) / 4.0);
    wb(1'b1, gtssc_pkg::ADDR_TBL + 8'h20, 32'(tv));
    wb(1'b0, gtssc_pkg::ADDR_TBL + 8'h20, 32'h0);
    chk("computed entry", 32'h0000_0068, rd);
    wb(1'b1, gtssc_pkg::ADDR_SLOPE, 32'h0000_4000);
    wb(1'b1, gtssc_pkg::ADDR_DELAY, 32'h0000_0005);
    cyc(4);
    chk("idle scaled hold", 32'(EXP_DAC), 32'(modDac));
  endtask : t_table
  // Transmit cycle with a start delay, shaping of a run of ones, ramp-down
  task t_tx(input logic [7:0] dly);
    int n;
    int trim;
    wb(1'b1, gtssc_pkg::ADDR_DELAY, {16'h0000, dly, 8'h05});
    wb(1'b1, gtssc_pkg::ADDR_CTRL, 32'h0000_0005);
    @(posedge clock);
    run <= 1'b1;
    fork
      begin
        n = 0;
        trim = 0;
        while (bitReq !== 1'b1 && n < 400) begin
          @(posedge clock);
          n++;
          if (trimActive === 1'b1) trim++;
        end
      end
      begin
        cyc(6);
        wb(1'b0, gtssc_pkg::ADDR_STATUS, 32'h0);
      end
    join
    if (n >= 400) hang("first bit");
    chk("trim length", 32'(dly) * 32'd25 + 32'd1, 32'(trim));
    if (dly != 8'h00) chk("history at start", 32'h0000_0002, {12'h0, rd[19:17], 12'h0, rd[4:0]});
    cyc(200);
    chk("full power", 32'h0000_00FF, {airData, stageEn, rampLevel});
    chk("shaped ones", 32'(EXP_DAC), 32'(modDac));
    run <= 1'b0;
    n = 0;
    while (stageEn !== 3'h0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n >= 100) hang("ramp down");
    wb(1'b0, gtssc_pkg::ADDR_STATUS, 32'h0);
    chk("idle after cycle", 32'h000E_0001, rd & 32'h000F_FFFF);
  endtask : t_tx
  // Receive cycle holds the first table entry
  task t_rx;
    // Transmit without narrow bandwidth is not a legal start and stays idle
    wb(1'b1, gtssc_pkg::ADDR_CTRL, 32'h0000_0001);
    @(posedge clock);
    run <= 1'b1;
    cyc(4);
    wb(1'b0, gtssc_pkg::ADDR_STATUS, 32'h0);
    chk("wide band refused", 32'h0000_0001, {27'h0, rd[4:0]});
    run <= 1'b0;
    cyc(2);
    wb(1'b1, gtssc_pkg::ADDR_CTRL, 32'h0000_0002);
    @(posedge clock);
    run <= 1'b1;
    cyc(4);
    wb(1'b0, gtssc_pkg::ADDR_STATUS, 32'h0);
    chk("receive state", 32'h0000_0008, {27'h0, rd[4:0]});
    chk("receive hold", 32'(EXP_DAC), {23'h0, trimActive, modDac});
    run <= 1'b0;
    cyc(4);
    wb(1'b0, gtssc_pkg::ADDR_STATUS, 32'h0);
    chk("receive end", 32'h0000_0001, {27'h0, rd[4:0]});
  endtask : t_rx
  // Main sequence
  initial begin
    rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    run = 1'b0;
    err_count = 0;
    total_checks = 0;
    cyc(20);
    chk("outputs in reset", 32'h0, {divRatio, airData, trimActive, stageEn, rampLevel, bitReq, wbAck});
    rst <= 1'b0;
    t_reset();
    t_synth();
    t_table();
    t_tx(8'h00);
    t_tx(8'h02);
    t_rx();
    test_done();
  end
endmodule : testbench
